// ==== rtl/serp_pkg.sv ====
// constants, types and helpers for the serial eeprom read path
`default_nettype none
package serp_pkg;
  localparam int unsigned AW        = 11;
  localparam int unsigned DW        = 8;
  localparam int unsigned TW        = AW + DW;
  localparam int unsigned MEM_DEPTH = 2048;
  localparam int unsigned FIFO_DEPTH = 2;

  // density codes
  localparam logic [2:0] DENS_1K  = 3'h0;
  localparam logic [2:0] DENS_2K  = 3'h1;
  localparam logic [2:0] DENS_4K  = 3'h2;
  localparam logic [2:0] DENS_8K  = 3'h3;
  localparam logic [2:0] DENS_16K = 3'h4;

  // top addresses per density
  localparam logic [AW-1:0] TOP_1K  = 11'h07f;
  localparam logic [AW-1:0] TOP_2K  = 11'h0ff;
  localparam logic [AW-1:0] TOP_4K  = 11'h1ff;
  localparam logic [AW-1:0] TOP_8K  = 11'h3ff;
  localparam logic [AW-1:0] TOP_16K = 11'h7ff;

  localparam logic [3:0]    DEV_TYPE   = 4'ha;
  localparam logic [AW-1:0] ADDR_RESET = 11'h000;
  localparam logic [AW-1:0] ADDR_STEP  = 11'h001;
  localparam logic [DW-1:0] IDLE_BYTE  = 8'hff;
  localparam logic [2:0]    LAST_BIT   = 3'h7;

  // link engine states
  typedef enum logic [2:0] {
    LNK_IDLE, LNK_DEV, LNK_DEV_ACK, LNK_ADDR, LNK_ADDR_ACK, LNK_WDATA, LNK_TX, LNK_TX_ACK
  } serp_link_e;

  // top address of a density
  function automatic logic [AW-1:0] addr_top(input logic [2:0] dens);
    case (dens)
      DENS_1K: addr_top = TOP_1K;
      DENS_2K: addr_top = TOP_2K;
      DENS_4K: addr_top = TOP_4K;
      DENS_8K: addr_top = TOP_8K;
      default: addr_top = TOP_16K;
    endcase
  endfunction

  // counter step with roll-over only above the smallest density
  function automatic logic [AW-1:0] next_addr(input logic [AW-1:0] a, input logic [2:0] dens);
    if (a != addr_top(dens))
      next_addr = a + ADDR_STEP;
    else if (dens == DENS_1K)
      next_addr = a;
    else
      next_addr = ADDR_RESET;
  endfunction

  // number of select bits that carry high address bits instead
  function automatic int page_bits(input logic [2:0] dens);
    case (dens)
      DENS_4K: page_bits = 1;
      DENS_8K: page_bits = 2;
      DENS_16K: page_bits = 3;
      default: page_bits = 0;
    endcase
  endfunction

  // slave address byte compare against type and straps
  function automatic logic dev_match(input logic [7:0] db, input logic [2:0] strap,
                                     input logic [2:0] dens);
    logic m;
    m = (db[7:4] == DEV_TYPE);
    for (int i = 0; i < 3; i++)
      if (i >= page_bits(dens) && db[i+1] != strap[i])
        m = 1'b0;
    dev_match = m;
  endfunction
endpackage
`default_nettype wire

// ==== rtl/serp_mem.sv ====
// byte array with one write port and a registered read port
`timescale 1ns/100ps
`default_nettype none
module serp_mem
(
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  // write port
  input  wire logic                     we,
  input  wire logic [serp_pkg::AW-1:0]  waddr,
  input  wire logic [serp_pkg::DW-1:0]  wdata,
  // read port
  input  wire logic [serp_pkg::AW-1:0]  raddr,
  output logic      [serp_pkg::DW-1:0]  rdata
);
  logic [serp_pkg::DW-1:0] cells [0:serp_pkg::MEM_DEPTH-1];

  // array write
  always_ff @(posedge clk)
  begin
    if (we)
      cells[waddr] <= wdata;
  end

  // read data one cycle after the address
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rdata <= '0;
    else
      rdata <= cells[raddr];
  end
endmodule
`default_nettype wire

// ==== rtl/serp_read_path.sv ====
// serial eeprom read path: link engine, prefetch buffer and clock crossings
`timescale 1ns/100ps
`default_nettype none
module serp_read_path
#(
  parameter logic [2:0] DENSITY = serp_pkg::DENS_16K
)
(
  // system clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  // two-wire link, clock from the master
  input  wire logic                     scl,
  input  wire logic                     sda_in,
  output logic                          sda_out,
  output logic                          sda_oe,
  // device select straps
  input  wire logic                     select_strap_bit0,
  input  wire logic                     select_strap_bit1,
  input  wire logic                     select_strap_bit2,
  // programming status and array load port
  input  wire logic                     prog_busy,
  input  wire logic                     mem_wr_en,
  input  wire logic [serp_pkg::AW-1:0]  mem_wr_addr,
  input  wire logic [serp_pkg::DW-1:0]  mem_wr_data
);
  localparam int unsigned AW = serp_pkg::AW;
  localparam int unsigned DW = serp_pkg::DW;
  localparam int unsigned TW = serp_pkg::TW;

  // ---- system clock side ----
  logic [AW-1:0]  fetch_ptr;
  logic [AW-1:0]  rd_tag;
  logic           rd_pend;
  logic [DW-1:0]  mem_rdata;
  logic [TW-1:0]  fifo_q [0:serp_pkg::FIFO_DEPTH-1];
  logic           fifo_wr_idx;
  logic           fifo_rd_idx;
  logic [1:0]     fifo_cnt;
  logic           push_valid;
  logic           push_ready;
  logic           pop_valid;
  logic           pop_ready;
  logic           fifo_wr;
  logic           fifo_rd;
  logic           issue;
  logic [TW-1:0]  xfer_word;
  logic           xfer_req;
  logic           load_s1;
  logic           load_s2;
  logic           load_s3;
  logic           load_evt;
  logic           ack_s1;
  logic           ack_s2;

  // ---- link clock side ----
  logic           st_tog;
  logic           sp_tog;
  logic           st_seen;
  logic           sp_seen;
  logic [3:0]     ctl_s1;
  logic [3:0]     ctl_s2;
  logic           req_s1;
  logic           req_s2;
  logic           ack_tog;
  logic           sda_smp;
  logic [7:0]     rx_sh;
  logic [7:0]     tx_sh;
  logic [2:0]     bit_cnt;
  logic           rd_mode;
  logic [2:0]     page;
  logic [AW-1:0]  exp_addr;
  logic [AW-1:0]  load_addr;
  logic           load_tog;
  serp_pkg::serp_link_e state;
  logic           start_evt;
  logic           stop_evt;
  logic           live;
  logic           word_valid;
  logic           word_hit;
  logic           load_pt;
  logic           take;
  logic           addr_done;
  logic [DW-1:0]  next_byte;

  // open drain: only ever pulls low
  assign sda_out = 1'b0;

  // array holding the data
  serp_mem u_mem
  (
    .clk   (clk),
    .rst_b (rst_b),
    .we    (mem_wr_en),
    .waddr (mem_wr_addr),
    .wdata (mem_wr_data),
    .raddr (fetch_ptr),
    .rdata (mem_rdata)
  );

  // address load and word ack events arriving from the link side
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      load_s1 <= 1'b0;
      load_s2 <= 1'b0;
      load_s3 <= 1'b0;
      ack_s1  <= 1'b0;
      ack_s2  <= 1'b0;
    end
    else
    begin
      load_s1 <= load_tog;
      load_s2 <= load_s1;
      load_s3 <= load_s2;
      ack_s1  <= ack_tog;
      ack_s2  <= ack_s1;
    end
  end

  assign load_evt   = load_s2 ^ load_s3;
  // buffer handshakes: fill from the array, drain into the crossing
  assign push_valid = rd_pend;
  assign push_ready = (fifo_cnt != 2'h2);
  assign pop_valid  = (fifo_cnt != 2'h0);
  assign pop_ready  = (xfer_req == ack_s2);
  assign fifo_wr    = push_valid && push_ready && !load_evt;
  assign fifo_rd    = pop_valid && pop_ready && !load_evt;
  // fetch only while the buffer has room for the read in flight
  assign issue      = !load_evt && ((fifo_cnt + {1'b0, rd_pend}) < 2'h2);

  // prefetch pointer, restarted whenever the link loads a new address
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fetch_ptr <= serp_pkg::ADDR_RESET;
      rd_tag    <= serp_pkg::ADDR_RESET;
      rd_pend   <= 1'b0;
    end
    else if (load_evt)
    begin
      fetch_ptr <= load_addr; // stable since its toggle
      rd_pend   <= 1'b0;
    end
    else if (issue)
    begin
      rd_tag    <= fetch_ptr;
      rd_pend   <= 1'b1;
      fetch_ptr <= serp_pkg::next_addr(fetch_ptr, DENSITY);
    end
    else if (fifo_wr)
      rd_pend <= 1'b0;
  end

  // buffer storage
  always_ff @(posedge clk)
  begin
    if (fifo_wr)
      fifo_q[fifo_wr_idx] <= {rd_tag, mem_rdata};
  end

  // buffer pointers and fill level, flushed on an address load
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fifo_wr_idx <= 1'b0;
      fifo_rd_idx <= 1'b0;
      fifo_cnt    <= 2'h0;
    end
    else if (load_evt)
    begin
      fifo_wr_idx <= 1'b0;
      fifo_rd_idx <= 1'b0;
      fifo_cnt    <= 2'h0;
    end
    else
    begin
      if (fifo_wr)
        fifo_wr_idx <= ~fifo_wr_idx;
      if (fifo_rd)
        fifo_rd_idx <= ~fifo_rd_idx;
      if (fifo_wr && !fifo_rd)
        fifo_cnt <= fifo_cnt + 2'h1;
      else if (fifo_rd && !fifo_wr)
        fifo_cnt <= fifo_cnt - 2'h1;
    end
  end

  // tagged word offered to the link side, held until acknowledged
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      xfer_word <= '0;
      xfer_req  <= 1'b0;
    end
    else if (fifo_rd)
    begin
      xfer_word <= fifo_q[fifo_rd_idx];
      xfer_req  <= ~xfer_req;
    end
  end

  // start: data falls while the clock is high
  always_ff @(negedge sda_in or negedge rst_b)
  begin
    if (!rst_b)
      st_tog <= 1'b0;
    else if (scl)
      st_tog <= ~st_tog;
  end

  // stop: data rises while the clock is high
  always_ff @(posedge sda_in or negedge rst_b)
  begin
    if (!rst_b)
      sp_tog <= 1'b0;
    else if (scl)
      sp_tog <= ~sp_tog;
  end

  // bits are taken on the rising clock edge
  always_ff @(posedge scl or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sda_smp <= 1'b1;
      rx_sh   <= 8'h00;
    end
    else
    begin
      sda_smp <= sda_in;
      rx_sh   <= {rx_sh[6:0], sda_in};
    end
  end

  // link-side view of the offered word and frame events
  assign start_evt  = (st_tog != st_seen); // settled half a clock earlier
  assign stop_evt   = (sp_tog != sp_seen);
  assign live       = !start_evt && !stop_evt;
  assign word_valid = (req_s2 != ack_tog);
  assign word_hit   = word_valid && (xfer_word[TW-1:DW] == exp_addr);
  assign next_byte  = word_hit ? xfer_word[DW-1:0] : serp_pkg::IDLE_BYTE;
  // a byte is due after the read ack or a master ack
  assign load_pt    = live && ((state == serp_pkg::LNK_DEV_ACK && rd_mode) ||
                               (state == serp_pkg::LNK_TX_ACK && !sda_smp));
  assign take       = word_valid && (load_pt || !word_hit);
  assign addr_done  = live && state == serp_pkg::LNK_ADDR && bit_cnt == serp_pkg::LAST_BIT;

  // synchronisers, frame event copies and word ack
  always_ff @(negedge scl or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctl_s1  <= 4'h0;
      ctl_s2  <= 4'h0;
      req_s1  <= 1'b0;
      req_s2  <= 1'b0;
      st_seen <= 1'b0;
      sp_seen <= 1'b0;
      ack_tog <= 1'b0;
    end
    else
    begin
      ctl_s1  <= {prog_busy, select_strap_bit2, select_strap_bit1, select_strap_bit0};
      ctl_s2  <= ctl_s1;
      req_s1  <= xfer_req;
      req_s2  <= req_s1;
      st_seen <= st_tog;
      sp_seen <= sp_tog;
      // stale words are dropped, due ones consumed
      if (take)
        ack_tog <= ~ack_tog;
    end
  end

  // link engine; data changes only while the clock is low
  always_ff @(negedge scl or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state  <= serp_pkg::LNK_IDLE;
      sda_oe <= 1'b0;
    end
    else if (start_evt)
    begin
      // every transfer opens with the slave address byte
      state  <= serp_pkg::LNK_DEV;
      sda_oe <= 1'b0;
    end
    else if (stop_evt)
    begin
      state  <= serp_pkg::LNK_IDLE;
      sda_oe <= 1'b0;
    end
    else
    begin
      unique case (state)
        serp_pkg::LNK_IDLE:
          sda_oe <= 1'b0;
        serp_pkg::LNK_DEV:
          if (bit_cnt == serp_pkg::LAST_BIT)
          begin
            // type and straps decide; silent while programming
            if (serp_pkg::dev_match(rx_sh, ctl_s2[2:0], DENSITY) && !ctl_s2[3])
            begin
              state  <= serp_pkg::LNK_DEV_ACK;
              sda_oe <= 1'b1;
            end
            else
              state <= serp_pkg::LNK_IDLE;
          end
        serp_pkg::LNK_DEV_ACK:
          if (rd_mode)
          begin
            // first data bit right after our ack
            state  <= serp_pkg::LNK_TX;
            sda_oe <= !next_byte[7];
          end
          else
          begin
            // write direction brings the byte address
            state  <= serp_pkg::LNK_ADDR;
            sda_oe <= 1'b0;
          end
        serp_pkg::LNK_ADDR:
          if (bit_cnt == serp_pkg::LAST_BIT)
          begin
            state  <= serp_pkg::LNK_ADDR_ACK;
            sda_oe <= 1'b1;
          end
        serp_pkg::LNK_ADDR_ACK:
        begin
          state  <= serp_pkg::LNK_WDATA;
          sda_oe <= 1'b0;
        end
        serp_pkg::LNK_WDATA:
          sda_oe <= 1'b0;
        serp_pkg::LNK_TX:
          if (bit_cnt == serp_pkg::LAST_BIT)
          begin
            // release for the master's ack bit
            state  <= serp_pkg::LNK_TX_ACK;
            sda_oe <= 1'b0;
          end
          else
            sda_oe <= !tx_sh[6];
        serp_pkg::LNK_TX_ACK:
          if (!sda_smp)
          begin
            state  <= serp_pkg::LNK_TX;
            sda_oe <= !next_byte[7];
          end
          else
          begin
            // no ack: stop driving and wait for the stop
            state  <= serp_pkg::LNK_IDLE;
            sda_oe <= 1'b0;
          end
      endcase
    end
  end

  // bit counter, wraps to zero after each byte
  always_ff @(negedge scl or negedge rst_b)
  begin
    if (!rst_b)
      bit_cnt <= 3'h0;
    else if (start_evt)
      bit_cnt <= 3'h0;
    else if (state == serp_pkg::LNK_DEV || state == serp_pkg::LNK_ADDR ||
             state == serp_pkg::LNK_TX)
      bit_cnt <= bit_cnt + 3'h1;
  end

  // direction and high address bits from the slave address byte
  always_ff @(negedge scl or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_mode <= 1'b0;
      page    <= 3'h0;
    end
    else if (live && state == serp_pkg::LNK_DEV && bit_cnt == serp_pkg::LAST_BIT)
    begin
      rd_mode <= rx_sh[0];
      page    <= rx_sh[3:1];
    end
  end

  // transmit shifter
  always_ff @(negedge scl or negedge rst_b)
  begin
    if (!rst_b)
      tx_sh <= serp_pkg::IDLE_BYTE;
    else if (load_pt)
      tx_sh <= next_byte;
    else if (state == serp_pkg::LNK_TX)
      tx_sh <= {tx_sh[6:0], 1'b1};
  end

  // address counter and address load event
  always_ff @(negedge scl or negedge rst_b)
  begin
    if (!rst_b)
    begin
      exp_addr  <= serp_pkg::ADDR_RESET;
      load_addr <= serp_pkg::ADDR_RESET;
      load_tog  <= 1'b0;
    end
    else if (addr_done)
    begin
      // dummy write sets the location for the next read
      exp_addr  <= {page, rx_sh} & serp_pkg::addr_top(DENSITY);
      load_addr <= {page, rx_sh} & serp_pkg::addr_top(DENSITY);
      load_tog  <= ~load_tog;
    end
    else if (load_pt)
      // last accessed plus one; roll-over per density
      exp_addr <= serp_pkg::next_addr(exp_addr, DENSITY);
  end
endmodule
`default_nettype wire

// ==== testbench/serp_checker.sv ====
// link side assertions for the serial eeprom read path
`timescale 1ns/100ps
`default_nettype none
module serp_checker
#(
  parameter logic [2:0] DENSITY = serp_pkg::DENS_16K
)
(
  // clocks and reset
  input wire logic clk,
  input wire logic rst_b,
  // link
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // straps and status
  input wire logic select_strap_bit0,
  input wire logic select_strap_bit1,
  input wire logic select_strap_bit2,
  input wire logic prog_busy
);
  localparam int PB = DENSITY == serp_pkg::DENS_16K ? 3 : DENSITY == serp_pkg::DENS_8K ? 2 :
                      DENSITY == serp_pkg::DENS_4K ? 1 : 0;
  logic       st_tog;
  logic       st_seen;
  logic       rd;
  logic       wr;
  logic       oe_r;
  logic [7:0] sr;
  int         bc;
  logic [2:0] msk;
  logic       hit;
  // straps that must match, page bits excluded
  assign msk = 3'h7 << PB;
  assign hit = sr[7:4] == 4'ha && ((sr[3:1] ^ {select_strap_bit2, select_strap_bit1,
               select_strap_bit0}) & msk) == 3'h0;
  // start seen as a data fall while the clock is high
  always_ff @(negedge sda_in or negedge rst_b)
    if (!rst_b)
      st_tog <= 1'b0;
    else if (scl)
      st_tog <= ~st_tog;
  // level held through the clock high phase
  always_ff @(posedge scl or negedge rst_b)
    if (!rst_b)
      oe_r <= 1'b0;
    else
      oe_r <= sda_oe;
  // falls since start, slave byte and frame kind
  always_ff @(negedge scl or negedge rst_b)
    if (!rst_b)
    begin
      st_seen <= 1'b0;
      bc      <= 0;
      sr      <= 8'h00;
      rd      <= 1'b0;
      wr      <= 1'b0;
    end
    else if (st_tog != st_seen)
    begin
      st_seen <= st_tog;
      bc      <= 0;
      rd      <= 1'b0;
      wr      <= 1'b0;
    end
    else
    begin
      bc <= bc + 1;
      if (bc < 8)
        sr <= {sr[6:0], sda_in};
      if (bc == 8)
      begin
        rd <= sda_oe & sr[0];
        wr <= sda_oe & ~sr[0];
      end
    end
  chk_sda_low: assert property (@(posedge clk) disable iff (!rst_b) sda_out == 1'b0)
    else $error("data line driven high");
  chk_listen_addr: assert property (@(negedge scl) disable iff (!rst_b) bc <= 7 |-> !sda_oe)
    else $error("data driven during slave byte");
  chk_ack_match: assert property (@(negedge scl) disable iff (!rst_b)
    bc == 8 && !prog_busy |-> sda_oe == hit) else $error("slave byte answer wrong");
  chk_busy_silent: assert property (@(negedge scl) disable iff (!rst_b)
    bc == 8 && prog_busy |-> !sda_oe) else $error("answer while busy");
  chk_addr_ack: assert property (@(negedge scl) disable iff (!rst_b)
    wr && bc == 17 |-> sda_oe) else $error("byte address not acked");
  chk_ack_release: assert property (@(negedge scl) disable iff (!rst_b)
    rd && bc >= 17 && (bc - 17) % 9 == 0 |-> !sda_oe) else $error("line held in ack slot");
  chk_nack_quiet: assert property (@(negedge scl) disable iff (!rst_b)
    rd && bc >= 17 && (bc - 17) % 9 == 0 && sda_in |=> !sda_oe) else $error("sent after nack");
  chk_bit_stands: assert property (@(negedge scl) disable iff (!rst_b) sda_oe == oe_r)
    else $error("data changed while clock high");
  cov_stream: cover property (@(negedge scl) rd && bc >= 17 && (bc - 17) % 9 == 0 && !sda_in);
  cov_dummy: cover property (@(negedge scl) wr && bc == 17 && sda_oe);
  cov_busy: cover property (@(negedge scl) bc == 8 && prog_busy);
endmodule
bind serp_read_path serp_checker #(.DENSITY(DENSITY)) serp_checker_inst (.clk(clk),
  .rst_b(rst_b), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .select_strap_bit0(select_strap_bit0), .select_strap_bit1(select_strap_bit1),
  .select_strap_bit2(select_strap_bit2), .prog_busy(prog_busy));
`default_nettype wire

// ==== testbench/serp_mst.sv ====
// two-wire bus master model for reads from the eeprom read path
`timescale 1ns/100ps
`default_nettype none
module serp_mst
(
  // link lines, a released line reads high through the pull-up
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_line
);
  int hp     = 80;
  int lo_ext = 0;
  // idle bus: clock stands high between frames
  initial
  begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end
  // one bit, data moved mid low phase, sampled at the rise
  task automatic bit_io(input logic b, output logic s);
    #(hp / 2 + lo_ext) sda_drv = b;
    #(hp / 2) scl = 1'b1;
    s = sda_line;
    #(hp) scl = 1'b0;
  endtask
  task automatic start();
    #(hp / 2) sda_drv = 1'b1;
    scl = 1'b1;
    #(hp / 2) sda_drv = 1'b0;
    #(hp / 2) scl = 1'b0;
  endtask
  // stop: data rises while the clock is high
  task automatic stop();
    #(hp / 2) sda_drv = 1'b0;
    #(hp / 2) scl = 1'b1;
    #(hp / 2) sda_drv = 1'b1;
  endtask
  // byte out msb first, returns the acknowledge
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  // byte in, acknowledged only when more is wanted
  task automatic get_byte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(~more, s);
  endtask
endmodule
`default_nettype wire

// ==== testbench/serp_read_path_tb_top.sv ====
// testbench: wide and narrow read paths against a counter and array model
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) cmp(8'(g), 8'(e));
module serp_read_path_tb_top;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        prog_busy = 1'b0;
  logic        mem_wr_en = 1'b0;
  logic        sel = 1'b0;
  logic [10:0] mem_wr_addr = 11'h000;
  logic [7:0]  mem_wr_data = 8'h00;
  logic [2:0]  strap = 3'h0;
  logic [7:0]  mem [2048];
  int          cnt [2] = '{0, 0};
  int          n_fail = 0;
  int          total_checks = 0;
  wire         m_scl;
  wire         m_sda;
  wire         oe0;
  wire         oe1;
  wire         out0;
  wire         out1;
  // two buses, only the selected one sees the master
  wire         scl0 = sel ? 1'b1 : m_scl;
  wire         scl1 = sel ? m_scl : 1'b1;
  wire         lvl0 = (sel ? 1'b1 : m_sda) & (~oe0 | out0);
  wire         lvl1 = (sel ? m_sda : 1'b1) & (~oe1 | out1);
  wire         lvl = sel ? lvl1 : lvl0;
  always #50 clk = ~clk;
  serp_mst serp_mst_inst (.scl(m_scl), .sda_drv(m_sda), .sda_line(lvl));
  serp_read_path #(.DENSITY(serp_pkg::DENS_16K)) serp_read_path_inst (.clk(clk), .rst_b(rst_b),
    .scl(scl0), .sda_in(lvl0), .sda_out(out0), .sda_oe(oe0), .select_strap_bit0(strap[0]),
    .select_strap_bit1(strap[1]), .select_strap_bit2(strap[2]), .prog_busy(prog_busy),
    .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data));
  serp_read_path #(.DENSITY(serp_pkg::DENS_1K)) serp_read_path_inst1 (.clk(clk), .rst_b(rst_b),
    .scl(scl1), .sda_in(lvl1), .sda_out(out1), .sda_oe(oe1), .select_strap_bit0(strap[0]),
    .select_strap_bit1(strap[1]), .select_strap_bit2(strap[2]), .prog_busy(prog_busy),
    .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data));
  // compare and count
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic report(input string s);
    $display("test %s done, mismatches %0d", s, n_fail);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // one slave byte and stop, acknowledge handed back
  task automatic probe(input logic [7:0] db, output logic ack);
    serp_mst_inst.start();
    serp_mst_inst.put_byte(db, ack);
    serp_mst_inst.stop();
  endtask
  // read n bytes; a below zero reads from the counter, else a dummy write first
  task automatic xfer(input int a, input int n);
    logic       ack;
    logic [7:0] d;
    logic [2:0] pg;
    int         top;
    top = sel ? 127 : 2047;
    if (a >= 0)
    begin
      pg = sel ? strap : a[10:8];
      // dummy write of the wanted location
      serp_mst_inst.start();
      serp_mst_inst.put_byte({4'ha, pg, 1'b0}, ack);
      `CHK(ack, 1'b1)
      serp_mst_inst.put_byte(a[7:0], ack);
      `CHK(ack, 1'b1)
      cnt[sel] = a & top;
    end
    pg = sel ? strap : cnt[sel][10:8];
    serp_mst_inst.start();
    serp_mst_inst.put_byte({4'ha, pg, 1'b1}, ack);
    `CHK(ack, 1'b1)
    for (int i = 0; i < n; i++)
    begin
      serp_mst_inst.get_byte(i < n - 1, d);
      `CHK(d, mem[cnt[sel]])
      cnt[sel] = cnt[sel] == top ? (sel ? top : 0) : cnt[sel] + 1;
    end
    serp_mst_inst.stop();
  endtask
  // watchdog at about 1.8 times the expected run of some 3.4 ms
  initial
  begin
    #6000000;
    n_fail++;
    stop_test();
  end
  initial
  begin
    logic ack;
    void'($urandom(32'h683d));
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    // preload top down; the narrow path's array is written in full, the same as the wide one
    for (int a = 2047; a >= 0; a--)
    begin
      @(negedge clk);
      mem[a] = 8'($urandom);
      mem_wr_en = 1'b1;
      mem_wr_addr = 11'(a);
      mem_wr_data = mem[a];
    end
    @(negedge clk);
    mem_wr_en = 1'b0;
    // second reset drops words prefetched before the array was loaded
    rst_b = 1'b0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    repeat (5) @(negedge clk);
    // counter starts at location 0 after reset
    xfer(-1, 2);
    report("reset");
    repeat (4) xfer($urandom_range(2047), 1);
    report("selective");
    xfer(-1, 3);
    report("immediate");
    // runs over a page bit and over the top
    xfer(11'h0fe, 4);
    xfer(11'h7fe, 4);
    report("wrap");
    // slow master, prefetch buffer stalls
    serp_mst_inst.lo_ext = 3000;
    xfer(11'h123, 3);
    serp_mst_inst.lo_ext = 0;
    report("stall");
    xfer(0, 2049);
    report("array");
    probe(8'h51, ack);
    `CHK(ack, 1'b0)
    @(negedge clk) prog_busy = 1'b1;
    probe(8'ha1, ack);
    `CHK(ack, 1'b0)
    @(negedge clk) prog_busy = 1'b0;
    xfer(-1, 1);
    report("refusal");
    @(negedge clk) strap = 3'($urandom);
    sel = 1'b1;
    probe({4'ha, ~strap, 1'b1}, ack);
    `CHK(ack, 1'b0)
    // narrow array holds at its top
    xfer(126, 4);
    xfer(-1, 1);
    report("narrow");
    stop_test();
  end
endmodule
`default_nettype wire
